//--- design/dio_byte_lane_port.sv
`timescale 1ns/1ps
`default_nettype none

module dio_byte_lane_port
    import dio_lane_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset,
    // Avalon-MM slave
    input  wire logic [3:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    output logic      [31:0]          o_avs_readdata,
    output logic                      o_avs_waitrequest,
    // Value sources
    input  wire logic [PORT_WIDTH-1:0] i_seq_value,
    input  wire logic                 i_seq_valid,
    input  wire logic [PORT_WIDTH-1:0] i_result_std_value,
    input  wire logic [PORT_WIDTH-1:0] i_result_sys_value,
    // Port pins
    input  wire logic [PORT_WIDTH-1:0] i_pin_in,
    output logic      [PORT_WIDTH-1:0] o_pin_out,
    output logic      [PORT_WIDTH-1:0] o_pin_oe,
    // Clock selection to the clock network
    output logic      [1:0]           o_clock_select
);

    // ==========================================================
    // Bus slave
    avmm_req_t                  req;
    logic                       ack_q;
    logic [1:0]                 source_q;
    logic [LANES-1:0]           drive_q;
    logic [PORT_WIDTH-1:0]      outval_q;
    logic [1:0]                 clksel_q;
    logic [PORT_WIDTH-1:0]      seq_q;
    logic [PORT_WIDTH-1:0]      sync1_q;
    logic [PORT_WIDTH-1:0]      sync2_q;
    logic [PORT_WIDTH-1:0]      value_d;
    logic [PORT_WIDTH-1:0]      pin_out_q;
    logic [PORT_WIDTH-1:0]      pin_oe_q;
    logic                       wr_take;

    assign req     = '{address: i_avs_address, read: i_avs_read, write: i_avs_write,
                       writedata: i_avs_writedata, byteenable: i_avs_byteenable};
    // One wait cycle per access; the access completes when ack is high
    assign wr_take = req.write && ack_q;
    assign o_avs_waitrequest = (req.read || req.write) && !ack_q;

    always_ff @(posedge i_clk) begin
        if (i_reset || ack_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req.read || req.write;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input avmm_req_t r);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (r.byteenable[b]) begin
                m[b*8 +: 8] = r.writedata[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            source_q <= SOURCE_RESET;
            drive_q  <= DRIVE_RESET;
            outval_q <= OUTVAL_RESET;
            clksel_q <= CLKSEL_RESET;
        end else if (wr_take) begin
            unique case (req.address)
                REG_SOURCE: if (req.byteenable[0]) begin
                    source_q <= req.writedata[1:0];
                end
                REG_DRIVE: if (req.byteenable[0]) begin
                    drive_q <= req.writedata[LANES-1:0];
                end
                REG_OUTVAL: outval_q <= merge(outval_q, req);
                REG_CLKSEL: if (req.byteenable[0] && req.writedata[1:0] != CLK_RESERVED) begin
                    clksel_q <= req.writedata[1:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_avs_readdata <= UNMAPPED_READ;
        end else if (req.read && !ack_q) begin
            unique case (req.address)
                REG_SOURCE:   o_avs_readdata <= {30'h0000_0000, source_q};
                REG_DRIVE:    o_avs_readdata <= {{(32-LANES){1'b0}}, drive_q};
                REG_OUTVAL:   o_avs_readdata <= outval_q;
                REG_INVAL:    o_avs_readdata <= sync2_q;
                REG_CLKSEL:   o_avs_readdata <= {30'h0000_0000, clksel_q};
                REG_PINSTATE: o_avs_readdata <= pin_out_q;
                default:      o_avs_readdata <= UNMAPPED_READ;
            endcase
        end
    end

    // ==========================================================
    // Input sampling
    // Two stages keep a pin changing near the edge from reaching software
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= i_pin_in;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // Output source and lane drive
    // Sequencer value holds between commands
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            seq_q <= '0;
        end else if (i_seq_valid) begin
            seq_q <= i_seq_value;
        end
    end

    always_comb begin
        unique case (port_output_source_select_t'(source_q))
            SRC_MANUAL:     value_d = outval_q;
            SRC_SEQUENCER:  value_d = seq_q;
            SRC_RESULT_STD: value_d = i_result_std_value;
            SRC_RESULT_SYS: value_d = i_result_sys_value;
        endcase
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_WIDTH-1:0] out_q;
        logic [LANE_WIDTH-1:0] oe_q;
        // Each lane owns its flops so no two processes write one variable
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                out_q <= '0;
                oe_q  <= '0;
            end else begin
                oe_q  <= {LANE_WIDTH{drive_q[l]}};
                out_q <= drive_q[l] ? value_d[l*LANE_WIDTH +: LANE_WIDTH] : '0;
            end
        end
        assign pin_out_q[l*LANE_WIDTH +: LANE_WIDTH] = out_q;
        assign pin_oe_q[l*LANE_WIDTH +: LANE_WIDTH]  = oe_q;
    end

    assign o_pin_out      = pin_out_q;
    assign o_pin_oe       = pin_oe_q;
    assign o_clock_select = clksel_q;

    // ==========================================================
    // Checks
    a_lane_oe_follows: assert property (@(posedge i_clk) disable iff (i_reset)
        ##1 !$past(i_reset) |-> o_pin_oe[7:0] == {8{$past(drive_q[0])}})
        else $error("lane 0 enable does not follow drive");
    a_undriven_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_pin_oe[31:24] == 8'h00) |-> o_pin_out[31:24] == 8'h00)
        else $error("undriven lane shows a value");
    a_manual_value: assert property (@(posedge i_clk) disable iff (i_reset)
        (source_q == SRC_MANUAL && drive_q[1]) ##1 !i_reset
        |-> o_pin_out[15:8] == $past(outval_q[15:8]))
        else $error("manual value not driven");
    a_seq_value: assert property (@(posedge i_clk) disable iff (i_reset)
        (source_q == SRC_SEQUENCER && drive_q[2] && i_seq_valid && $stable(source_q))
        |-> ##2 o_pin_out[23:16] == $past(i_seq_value[23:16], 2) || !drive_q[2])
        else $error("sequencer value not driven");
    a_result_sys: assert property (@(posedge i_clk) disable iff (i_reset)
        (source_q == SRC_RESULT_SYS && drive_q[3]) |=> o_pin_out[31:24]
        == $past(i_result_sys_value[31:24]))
        else $error("result value not driven");
    a_input_delay: assert property (@(posedge i_clk) disable iff (i_reset)
        !$past(i_reset) && !$past(i_reset, 2) |-> sync2_q == $past(i_pin_in, 2))
        else $error("input not two stages late");
    a_bus_answer: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_avs_read && o_avs_waitrequest && i_avs_address == REG_INVAL)
        |=> !o_avs_waitrequest && o_avs_readdata == $past(sync2_q))
        else $error("input read wrong");
    a_clock_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        o_clock_select != CLK_RESERVED)
        else $error("reserved clock selection");
    a_result_std: assert property (@(posedge i_clk) disable iff (i_reset)
        (source_q == SRC_RESULT_STD && drive_q[0]) |=> o_pin_out[7:0]
        == $past(i_result_std_value[7:0]))
        else $error("standard result value not driven");
    a_write_lands: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && i_avs_address == REG_OUTVAL
        && i_avs_byteenable == 4'hF) |=> outval_q == $past(i_avs_writedata))
        else $error("output value write lost");
    a_drive_lands: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_avs_write && !o_avs_waitrequest && i_avs_address == REG_DRIVE
        && i_avs_byteenable[0]) |=> drive_q == $past(i_avs_writedata[LANES-1:0]))
        else $error("drive write lost");

endmodule : dio_byte_lane_port

`default_nettype wire

//--- include/dio_lane_pkg.sv
package dio_lane_pkg;

    // ==========================================================
    // Port geometry
    localparam int LANE_COUNT = 4;
    localparam int LANE_WIDTH = 8;
    localparam int PORT_WIDTH = LANE_COUNT * LANE_WIDTH;

    // ==========================================================
    // Register word indices (byte address = 4 * index)
    localparam logic [3:0] REG_SOURCE   = 4'h0;
    localparam logic [3:0] REG_DRIVE    = 4'h1;
    localparam logic [3:0] REG_OUTVAL   = 4'h2;
    localparam logic [3:0] REG_INVAL    = 4'h3;
    localparam logic [3:0] REG_CLKSEL   = 4'h4;
    localparam logic [3:0] REG_PINSTATE = 4'h5;

    // ==========================================================
    // Reset values
    localparam logic [1:0]  SOURCE_RESET = 2'h0;
    localparam logic [3:0]  DRIVE_RESET  = 4'h0;
    localparam logic [31:0] OUTVAL_RESET = 32'h0000_0000;
    localparam logic [1:0]  CLKSEL_RESET = 2'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ==========================================================
    // Clocking figures
    localparam int SYS_CLK_HZ  = 50_000_000;
    localparam int FAST_CLK_HZ = 56_250_000;
    localparam int EXT_MIN_HZ  = 1;
    localparam int EXT_MAX_HZ  = 56_250_000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SRC_MANUAL,
        SRC_SEQUENCER,
        SRC_RESULT_STD,
        SRC_RESULT_SYS
    } port_output_source_select_t;

    typedef enum logic [1:0] {
        CLK_INTERNAL_FAST,
        CLK_EXTERNAL_PIN,
        CLK_INTERNAL_SLOW,
        CLK_RESERVED
    } clock_select_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avmm_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic        valid;
    } source_word_t;

endpackage : dio_lane_pkg

//--- verif/dio_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// External equipment on the connector
module dio_far_end (
    // Device side of the pins
    input  wire logic [31:0] i_pin_oe,
    input  wire logic [31:0] i_pin_out,
    // Value the equipment drives when the device lets go
    input  wire logic [31:0] i_far_value,
    // Resolved wire level
    output logic      [31:0] o_pin_level
);
    // Equipment only drives lanes the device is not driving, so no contention
    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_far_value);
endmodule : dio_far_end

`default_nettype wire

//--- verif/tb_dio_byte_lane_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dio_byte_lane_port;
    import dio_lane_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [3:0]  be = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        seq_valid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] seq_v = 32'h0000_0000;
    logic [31:0] std_v = 32'h5A5A_0001;
    logic [31:0] sys_v = 32'h0F0F_8002;
    logic [31:0] far_v = 32'h1234_5678;
    logic [31:0] rdata, pin_lvl, pin_out, pin_oe, got;
    logic [31:0] exp_src [4];
    logic [3:0]  reset_regs [5];
    logic [1:0]  clk_sel;
    logic        wait_req;
    int          num_errors = 0;
    int          total_checks = 0;

    always #10 i_clk = ~i_clk;

    dio_byte_lane_port dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_seq_value(seq_v),
        .i_seq_valid(seq_valid), .i_result_std_value(std_v), .i_result_sys_value(sys_v),
        .i_pin_in(pin_lvl), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_clock_select(clk_sel));

    dio_far_end far_u (.i_pin_oe(pin_oe), .i_pin_out(pin_out), .i_far_value(far_v),
        .o_pin_level(pin_lvl));

    task automatic conclude();
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request stands until the rising edge that sees waitrequest low
    task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] b);
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        wr    <= w;
        rd    <= !w;
        @(posedge i_clk);
        while (wait_req !== 1'b0) @(posedge i_clk);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : access

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0000_0000, 4'h0);
        check(what, exp, got);
    endtask : rd_chk

    task automatic settle();
        repeat (3) @(posedge i_clk);
    endtask : settle

    // ==========================================================
    // Tests
    initial begin
        reset_regs = '{REG_SOURCE, REG_DRIVE, REG_OUTVAL, REG_CLKSEL, 4'hF};
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        foreach (reset_regs[i]) rd_chk("reset value", reset_regs[i], 32'h0000_0000);
        check("idle enables", 32'h0000_0000, pin_oe);
        check("idle waitrequest", 32'h0000_0000, {31'h0, wait_req});
        access(1'b1, REG_OUTVAL, 32'hA5C3_0F96, 4'hF);
        access(1'b1, REG_DRIVE, 32'h0000_0005, 4'hF);
        settle();
        check("lane enables", 32'h00FF_00FF, pin_oe);
        check("driven pins", 32'h00C3_0096, pin_out);
        rd_chk("pin state", REG_PINSTATE, 32'h00C3_0096);
        access(1'b1, REG_OUTVAL, 32'hFFFF_3CFF, 4'b0010);
        rd_chk("merged output", REG_OUTVAL, 32'hA5C3_3C96);
        rd_chk("input value", REG_INVAL, 32'h12C3_5696);
        // A new level must not show before two sync stages have passed
        @(posedge i_clk);
        far_v <= 32'h8700_E100;
        rd_chk("input sync delay", REG_INVAL, 32'h12C3_5696);
        rd_chk("input value new", REG_INVAL, 32'h87C3_E196);
        @(posedge i_clk);
        seq_v <= 32'hC001_D00D;
        seq_valid <= 1'b1;
        @(posedge i_clk);
        seq_v <= 32'h0000_FFFF;
        seq_valid <= 1'b0;
        access(1'b1, REG_DRIVE, 32'h0000_000F, 4'hF);
        exp_src = '{32'hA5C3_3C96, 32'hC001_D00D, 32'h5A5A_0001, 32'h0F0F_8002};
        for (int s = 0; s < 4; s++) begin
            access(1'b1, REG_SOURCE, 32'(s), 4'hF);
            settle();
            check("source output", exp_src[s], pin_out);
        end
        access(1'b1, REG_SOURCE, 32'h0000_0001, 4'hF);
        seq_v <= 32'h3C5A_96E1;
        seq_valid <= 1'b1;
        @(posedge i_clk);
        seq_valid <= 1'b0;
        settle();
        check("sequencer update", 32'h3C5A_96E1, pin_out);
        for (int c = 0; c < 3; c++) begin
            access(1'b1, REG_CLKSEL, 32'(c), 4'hF);
            settle();
            check("clock option", 32'(c), {30'h0, clk_sel});
        end
        access(1'b1, REG_CLKSEL, 32'h0000_0003, 4'hF);
        rd_chk("clock option kept", REG_CLKSEL, 32'h0000_0002);
        conclude();
    end

    initial begin
        repeat (3000) @(posedge i_clk);
        num_errors++;
        conclude();
    end
endmodule : tb_dio_byte_lane_port

`default_nettype wire
